// >>> rtl/pacd_pkg.sv
package pacd_pkg;
  typedef enum logic [1:0] {
    pacd_idle = 2'b00,
    pacd_run = 2'b01
  } pacd_diag_state_t;
  // [4]=pause, [3]=100 full, [2]=100 half, [1]=10 full, [0]=10 half
  typedef logic [4:0] pacd_caps_t;
endpackage : pacd_pkg

// >>> rtl/pacd_regbank.sv
// Notes on behaviour
// [RULE1] Upper PHY identifier is a constant read-only word; writes do nothing.
// [RULE2] Advertisement next-page and remote-fault bits always read zero.
// [RULE3] Advertised pause bit resets to one, shared with port control bit 4.
// [RULE4] Advertised speed/duplex bits reset to one, shared with port control 3..0.
// [RULE5] Advertisement selector reads 0x01; reserved bits read zero.
// [RULE6] Partner pause bit is read-only, resets zero, seen in port status bit 4.
// [RULE7] Partner speed/duplex bits read-only, reset zero, mirrored in port status.
// [RULE8] Partner next-page, acknowledge and remote-fault bits read zero.
// [RULE9] Cable test result code: normal, open, short, failed; resets zero.
// [RULE10] Writing one starts the cable test; hardware clears it when done.
// [RULE11] Software waits for start bit to read zero before using results.
// [RULE12] Force-link bit forces link pass when set; resets zero.
// [RULE13] Near-end loopback bit returns line receive to transmit; resets zero.
// [RULE14] Fault count is nine read-only bits; distance about 0.4 m each.
// [RULE15] Partner fields load on each negotiation completion and hold otherwise.
`timescale 1ns/1ps
`include "pacd_regs.svh"

module pacd_regbank
  import pacd_pkg::*;
#(
  parameter logic [15:0] ID_UPPER = 16'h5a5a, // Arbitrary identity value
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic an_done,
  input wire logic [15:0] partner_page,
  output logic [15:0] adv_page,
  output logic diag_start,
  input wire logic diag_done,
  input wire logic [1:0] diag_result,
  input wire logic [8:0] diag_count,
  output logic force_link,
  output logic near_loopback,
  output logic irq
);

  logic rdy;
  logic err;
  logic hit;
  logic [15:0] rd_word;
  logic wr_en;
  logic [8:0] idx;
  pacd_caps_t caps;
  pacd_caps_t lp_caps;
  pacd_diag_state_t state;
  logic [1:0] res;
  logic [8:0] cnt;
  logic busy;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic [1:0] irq_set;
  logic [15:0] diag_word;

  assign idx = paddr[10:2];
  assign busy = (state == pacd_run);

  // One wait state so read data can come from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy <= 1'b0;
    end else begin
      rdy <= psel && penable && !rdy;
    end
  end

  assign pready = rdy;
  // Gated by the decode so an unmapped address, paddr[11] set too, cannot alias a store
  assign wr_en = psel && penable && rdy && pwrite && hit;

  always_comb begin
    hit = 1'b1;
    rd_word = 16'h0000;
    if (paddr[ADDR_W-1:11] != '0) begin
      hit = 1'b0;
    end else begin
      case (idx)
        `PACD_IDX_ID_UPPER: rd_word = ID_UPPER; // RULE1
        `PACD_IDX_ADVERT: rd_word = adv_page;
        `PACD_IDX_PARTNER: begin
          rd_word = 16'h0000; // RULE8
          rd_word[`PACD_PAUSE_BIT] = lp_caps[4]; // RULE6
          rd_word[`PACD_CAP_MSB:`PACD_CAP_LSB] = lp_caps[3:0]; // RULE7
          rd_word[4:0] = `PACD_SEL_VALUE;
        end
        `PACD_IDX_DIAG: rd_word = diag_word;
        `PACD_IDX_PORT_CTRL: rd_word = {11'h000, caps}; // RULE3 RULE4
        `PACD_IDX_PORT_STAT: rd_word = {11'h000, lp_caps}; // RULE6 RULE7
        `PACD_IDX_IRQ_STAT: rd_word = {14'h0000, irq_stat};
        `PACD_IDX_IRQ_MASK: rd_word = {14'h0000, irq_mask};
        default: hit = 1'b0;
      endcase
    end
  end

  // Read data and error are captured in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      err <= 1'b0;
    end else if (psel && penable && !rdy) begin
      prdata <= pwrite ? 32'h0000_0000 : {16'h0000, rd_word};
      err <= !hit;
    end
  end

  assign pslverr = rdy && err;

  // Advertisement image; fixed fields are wired, not stored
  always_comb begin
    adv_page = 16'h0000; // RULE2
    adv_page[`PACD_PAUSE_BIT] = caps[4]; // RULE3
    adv_page[`PACD_CAP_MSB:`PACD_CAP_LSB] = caps[3:0]; // RULE4
    adv_page[4:0] = `PACD_SEL_VALUE; // RULE5
  end

  // Single store behind both the advertisement and port control views
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      caps <= `PACD_CAPS_RST;
    end else if (wr_en && idx == `PACD_IDX_ADVERT) begin
      caps <= {pwdata[`PACD_PAUSE_BIT], pwdata[`PACD_CAP_MSB:`PACD_CAP_LSB]}; // RULE3 RULE4
    end else if (wr_en && idx == `PACD_IDX_PORT_CTRL) begin
      caps <= pwdata[4:0]; // RULE3 RULE4
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lp_caps <= `PACD_LP_RST;
    end else if (an_done) begin
      lp_caps <= {partner_page[`PACD_PAUSE_BIT],
                  partner_page[`PACD_CAP_MSB:`PACD_CAP_LSB]}; // RULE15
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_link <= 1'b0;
      near_loopback <= 1'b0;
    end else if (wr_en && idx == `PACD_IDX_DIAG) begin
      force_link <= pwdata[`PACD_FORCE_BIT]; // RULE12
      near_loopback <= pwdata[`PACD_LOOP_BIT]; // RULE13
    end
  end

  // Cable test sequencer; a done strobe outside a test is ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= pacd_idle;
      diag_start <= 1'b0;
    end else begin
      diag_start <= 1'b0;
      case (state)
        pacd_idle: begin
          if (wr_en && idx == `PACD_IDX_DIAG && pwdata[`PACD_DIAG_EN_BIT]) begin
            state <= pacd_run; // RULE10
            diag_start <= 1'b1;
          end
        end
        pacd_run: begin
          if (diag_done) begin
            state <= pacd_idle; // RULE10
          end
        end
        default: state <= pacd_idle;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res <= 2'b00;
      cnt <= 9'h000;
    end else if (busy && diag_done) begin
      res <= diag_result; // RULE9
      cnt <= diag_count; // RULE14
    end
  end

  always_comb begin
    diag_word = 16'h0000;
    diag_word[`PACD_RES_MSB:`PACD_RES_LSB] = res; // RULE9
    diag_word[`PACD_DIAG_EN_BIT] = busy; // RULE10
    diag_word[`PACD_FORCE_BIT] = force_link;
    diag_word[`PACD_LOOP_BIT] = near_loopback;
    diag_word[`PACD_CNT_MSB:0] = cnt; // RULE14
  end

  // Sticky events; a set in the clearing cycle survives the clear
  assign irq_set = {an_done, busy && diag_done};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= `PACD_IRQ_RST;
    end else if (wr_en && idx == `PACD_IDX_IRQ_STAT) begin
      irq_stat <= (irq_stat & ~pwdata[1:0]) | irq_set;
    end else begin
      irq_stat <= irq_stat | irq_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= `PACD_IRQ_RST;
    end else if (wr_en && idx == `PACD_IDX_IRQ_MASK) begin
      irq_mask <= pwdata[1:0];
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic rd_done;
  assign rd_done = psel && penable && rdy && !pwrite;

  id_read_const_a: assert property ( // RULE1
    rd_done && idx == `PACD_IDX_ID_UPPER && hit |-> prdata == {16'h0000, ID_UPPER})
    else $error("upper id read wrong");

  adv_fixed_a: assert property ( // RULE2
    rd_done && idx == `PACD_IDX_ADVERT && hit |->
      prdata[15:11] == 5'h00 && prdata[9] == 1'b0)
    else $error("advertisement fixed bits not zero");

  adv_selector_a: assert property ( // RULE5
    rd_done && idx == `PACD_IDX_ADVERT && hit |-> prdata[4:0] == `PACD_SEL_VALUE)
    else $error("selector field wrong");

  pause_alias_a: assert property ( // RULE3
    wr_en && idx == `PACD_IDX_PORT_CTRL |=>
      adv_page[`PACD_PAUSE_BIT] == $past(pwdata[4]))
    else $error("pause alias not seen");

  caps_alias_a: assert property ( // RULE4
    wr_en && idx == `PACD_IDX_ADVERT |=>
      caps[3:0] == $past(pwdata[8:5]) ##1 $stable(caps) [*1])
    else $error("capability alias not seen");

  lp_capture_a: assert property ( // RULE15
    an_done |=> lp_caps == {$past(partner_page[10]), $past(partner_page[8:5])})
    else $error("partner ability not captured");

  lp_hold_a: assert property ( // RULE6
    !an_done |=> $stable(lp_caps))
    else $error("partner ability changed without completion");

  lp_zero_a: assert property ( // RULE8
    rd_done && idx == `PACD_IDX_PARTNER && hit |-> prdata[15:13] == 3'b000)
    else $error("partner unsupported bits set");

  diag_begin_a: assert property ( // RULE10
    !busy && wr_en && idx == `PACD_IDX_DIAG && pwdata[12] |=> diag_start && busy)
    else $error("cable test did not start");

  diag_finish_a: assert property ( // RULE9
    busy && diag_done |=> !busy && res == $past(diag_result) && cnt == $past(diag_count))
    else $error("cable test results not latched");

  force_loop_a: assert property ( // RULE12
    wr_en && idx == `PACD_IDX_DIAG |=>
      force_link == $past(pwdata[11]) && near_loopback == $past(pwdata[9]))
    else $error("force or loopback not written");

  // Read data was captured one edge back, so reads compare with the state of that cycle
  count_read_a: assert property ( // RULE14
    rd_done && idx == `PACD_IDX_DIAG && hit |-> prdata[8:0] == $past(cnt))
    else $error("fault count read wrong");

  pause_adv_a: assert property ( // RULE3
    wr_en && idx == `PACD_IDX_ADVERT |=>
      caps[4] == $past(pwdata[`PACD_PAUSE_BIT]))
    else $error("pause write not stored");

  ctrl_caps_a: assert property ( // RULE4
    wr_en && idx == `PACD_IDX_PORT_CTRL |=>
      adv_page[`PACD_CAP_MSB:`PACD_CAP_LSB] == $past(pwdata[3:0]))
    else $error("port control capabilities not advertised");

  caps_hold_a: assert property ( // RULE3
    !(wr_en && (idx == `PACD_IDX_ADVERT || idx == `PACD_IDX_PORT_CTRL)) |=>
      $stable(caps))
    else $error("capabilities changed without a write");

  ctrl_read_a: assert property ( // RULE4
    rd_done && idx == `PACD_IDX_PORT_CTRL && hit |->
      prdata[15:0] == {11'h000, $past(caps)})
    else $error("port control read wrong");

  partner_pause_a: assert property ( // RULE6
    rd_done && idx == `PACD_IDX_PARTNER && hit |->
      prdata[`PACD_PAUSE_BIT] == $past(lp_caps[4]))
    else $error("partner pause read wrong");

  partner_caps_a: assert property ( // RULE7
    rd_done && idx == `PACD_IDX_PARTNER && hit |->
      prdata[`PACD_CAP_MSB:`PACD_CAP_LSB] == $past(lp_caps[3:0]))
    else $error("partner capabilities read wrong");

  port_stat_a: assert property ( // RULE7
    rd_done && idx == `PACD_IDX_PORT_STAT && hit |->
      prdata[15:0] == {11'h000, $past(lp_caps)})
    else $error("port status mirror wrong");

  partner_resv_a: assert property ( // RULE8
    rd_done && idx == `PACD_IDX_PARTNER && hit |->
      prdata[12:11] == 2'b00 && prdata[9] == 1'b0 && prdata[4:0] == `PACD_SEL_VALUE)
    else $error("partner fixed bits wrong");

  result_read_a: assert property ( // RULE9
    rd_done && idx == `PACD_IDX_DIAG && hit |->
      prdata[`PACD_RES_MSB:`PACD_RES_LSB] == $past(res))
    else $error("cable result read wrong");

  diag_resv_a: assert property ( // RULE9
    rd_done && idx == `PACD_IDX_DIAG && hit |->
      prdata[15] == 1'b0 && prdata[10] == 1'b0)
    else $error("cable test reserved bits set");

  result_hold_a: assert property ( // RULE9
    !(busy && diag_done) |=>
      $stable(res) && $stable(cnt))
    else $error("cable results changed outside a finish");

  diag_flag_read_a: assert property ( // RULE10
    rd_done && idx == `PACD_IDX_DIAG && hit |->
      prdata[`PACD_DIAG_EN_BIT] == $past(busy))
    else $error("cable test flag read wrong");

  start_pulse_a: assert property ( // RULE10
    diag_start |->
      busy ##1 !diag_start)
    else $error("start pulse not single");

  busy_hold_a: assert property ( // RULE10
    busy && !diag_done |=>
      busy)
    else $error("cable test ended early");

  diag_irq_a: assert property ( // RULE10
    busy && diag_done |=>
      irq_stat[`PACD_IRQ_DIAG])
    else $error("cable test event not flagged");

  an_irq_a: assert property ( // RULE15
    an_done |=>
      irq_stat[`PACD_IRQ_AN])
    else $error("negotiation event not flagged");

  control_hold_a: assert property ( // RULE12
    !(wr_en && idx == `PACD_IDX_DIAG) |=>
      $stable(force_link) && $stable(near_loopback))
    else $error("force or loopback changed without a write");

  diag_run_c: cover property (diag_start ##[1:50] busy && diag_done);
  lp_read_c: cover property (rd_done && idx == `PACD_IDX_PARTNER);
  an_load_c: cover property (an_done ##1 lp_caps != `PACD_LP_RST);
  irq_rise_c: cover property (!irq ##1 irq);
  err_c: cover property (pslverr);

endmodule : pacd_regbank

// >>> rtl/pacd_regs.svh
`ifndef PACD_REGS_SVH
`define PACD_REGS_SVH
// Word indices; byte address is four times the index
`define PACD_IDX_ID_UPPER 9'h0ea
`define PACD_IDX_ADVERT 9'h0ec
`define PACD_IDX_PARTNER 9'h0ee
`define PACD_IDX_DIAG 9'h0f4
`define PACD_IDX_PORT_CTRL 9'h0f6
`define PACD_IDX_PORT_STAT 9'h0f8
`define PACD_IDX_IRQ_STAT 9'h100
`define PACD_IDX_IRQ_MASK 9'h101
// Field positions
`define PACD_PAUSE_BIT 10
`define PACD_CAP_LSB 5
`define PACD_CAP_MSB 8
`define PACD_SEL_VALUE 5'h01
`define PACD_RES_LSB 13
`define PACD_RES_MSB 14
`define PACD_DIAG_EN_BIT 12
`define PACD_FORCE_BIT 11
`define PACD_LOOP_BIT 9
`define PACD_CNT_MSB 8
// Reset values
`define PACD_CAPS_RST 5'h1f
`define PACD_LP_RST 5'h00
`define PACD_IRQ_RST 2'h0
// Interrupt bits
`define PACD_IRQ_DIAG 0
`define PACD_IRQ_AN 1
`endif

// >>> tb/pacd_far_model.sv
`timescale 1ns/1ps

// Stands in for the negotiation engine and the cable tester on the line side
module pacd_far_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic diag_start,
  input wire logic an_go,
  input wire logic [15:0] lp_page,
  input wire logic [1:0] res,
  input wire logic [8:0] cnt,
  output logic an_done,
  output logic [15:0] partner_page,
  output logic diag_done,
  output logic [1:0] diag_result,
  output logic [8:0] diag_count
);
  logic busy;
  logic [4:0] wait_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      wait_cnt <= 5'h00;
      diag_done <= 1'b0;
      an_done <= 1'b0;
    end else begin
      an_done <= an_go;
      diag_done <= 1'b0;
      if (diag_start) begin
        busy <= 1'b1;
        wait_cnt <= 5'h09;
      end else if (busy && wait_cnt == 5'h00) begin
        busy <= 1'b0;
        diag_done <= 1'b1;
      end else if (busy) begin
        wait_cnt <= wait_cnt - 5'h01;
      end
    end
  end
  // Outside their strobe the data lines carry the inverse, so a stale capture shows
  assign partner_page = an_done ? lp_page : ~lp_page;
  assign diag_result = diag_done ? res : ~res;
  assign diag_count = diag_done ? cnt : ~cnt;
endmodule : pacd_far_model

// >>> tb/testbench.sv
`timescale 1ns/1ps
`include "pacd_regs.svh"

module testbench;
  localparam logic [15:0] ID_VAL = 16'h3c69; // Arbitrary identity value
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic an_go, an_done, diag_start, diag_done, force_link, near_loopback, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] partner_page, adv_page, lp_page;
  logic [1:0] diag_result, res;
  logic [8:0] diag_count, cnt;
  int error_cnt = 0;
  int n_compared = 0;
  int t;

  pacd_regbank #(.ID_UPPER(ID_VAL), .ADDR_W(12)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .an_done(an_done), .partner_page(partner_page), .adv_page(adv_page),
    .diag_start(diag_start), .diag_done(diag_done), .diag_result(diag_result),
    .diag_count(diag_count), .force_link(force_link), .near_loopback(near_loopback),
    .irq(irq));

  pacd_far_model far (
    .pclk(pclk), .presetn(presetn), .diag_start(diag_start), .an_go(an_go),
    .lp_page(lp_page), .res(res), .cnt(cnt), .an_done(an_done),
    .partner_page(partner_page), .diag_done(diag_done), .diag_result(diag_result),
    .diag_count(diag_count));

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_bit

  // Entered just after a rising edge; leaves one idle cycle so psel is never set twice
  task automatic apb(input logic w, input logic [8:0] idx, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {1'b0, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rchk(input logic [8:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk_word(rd, exp);
  endtask : rchk

  task automatic an_event(input logic [15:0] p);
    lp_page <= p;
    an_go <= 1'b1;
    @(posedge pclk);
    an_go <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : an_event

  task end_of_test;
    $display("compared %0d, mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial begin
    repeat (5000) @(posedge pclk);
    error_cnt++;
    end_of_test();
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, an_go} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    lp_page = 16'h0000;
    res = 2'h0;
    cnt = 9'h000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_word({16'h0, adv_page}, 32'h05e1);
    chk_bit(force_link | near_loopback | irq, 1'b0);
    rchk(`PACD_IDX_ID_UPPER, {16'h0, ID_VAL});
    rchk(`PACD_IDX_ADVERT, 32'h05e1);
    rchk(`PACD_IDX_PARTNER, 32'h0001);
    rchk(`PACD_IDX_DIAG, 32'h0);
    rchk(`PACD_IDX_PORT_CTRL, 32'h1f);
    rchk(`PACD_IDX_PORT_STAT, 32'h0);
    apb(1'b1, `PACD_IDX_ID_UPPER, 32'hffff);
    rchk(`PACD_IDX_ID_UPPER, {16'h0, ID_VAL});
    apb(1'b1, `PACD_IDX_ADVERT, 32'hffff_ffff);
    rchk(`PACD_IDX_ADVERT, 32'h05e1);
    apb(1'b1, `PACD_IDX_ADVERT, 32'h0);
    rchk(`PACD_IDX_PORT_CTRL, 32'h0);
    rchk(`PACD_IDX_ADVERT, 32'h0001);
    apb(1'b1, `PACD_IDX_PORT_CTRL, 32'h15);
    rchk(`PACD_IDX_ADVERT, 32'h04a1);
    chk_word({16'h0, adv_page}, 32'h04a1);
    apb(1'b0, 9'h0f0, 32'h0);
    chk_word(rd, 32'h0);
    chk_bit(err, 1'b1);
    apb(1'b1, 9'h0f0, 32'hffff);
    chk_bit(err, 1'b1);
    apb(1'b1, `PACD_IDX_IRQ_MASK, 32'h2);
    an_event(16'hfde0);
    chk_bit(irq, 1'b1);
    rchk(`PACD_IDX_PARTNER, 32'h05e1);
    rchk(`PACD_IDX_PORT_STAT, 32'h1f);
    rchk(`PACD_IDX_IRQ_STAT, 32'h2);
    rchk(`PACD_IDX_PARTNER, 32'h05e1);
    apb(1'b1, `PACD_IDX_IRQ_STAT, 32'h2);
    chk_bit(irq, 1'b0);
    an_event(16'h0120);
    rchk(`PACD_IDX_PARTNER, 32'h0121);
    rchk(`PACD_IDX_PORT_STAT, 32'h09);
    chk_bit(irq, 1'b1);
    apb(1'b1, `PACD_IDX_IRQ_STAT, 32'h2);
    // Each result code once, alternating the two control bits
    for (int i = 0; i < 4; i++) begin
      res <= 2'(i);
      cnt <= 9'h1ff - 9'(i * 170);
      apb(1'b1, `PACD_IDX_DIAG, i[0] ? 32'h1a00 : 32'h1000);
      apb(1'b0, `PACD_IDX_DIAG, 32'h0);
      chk_bit(rd[12], 1'b1);
      t = 0;
      do begin
        apb(1'b0, `PACD_IDX_DIAG, 32'h0);
        t++;
      end while (rd[12] !== 1'b0 && t < 30);
      chk_word(rd, {17'h0, 2'(i), 1'b0, i[0], 1'b0, i[0], cnt});
      chk_bit(force_link, i[0]);
      chk_bit(near_loopback, i[0]);
    end
    chk_bit(irq, 1'b0);
    rchk(`PACD_IDX_IRQ_STAT, 32'h1);
    apb(1'b1, `PACD_IDX_IRQ_MASK, 32'h3);
    chk_bit(irq, 1'b1);
    apb(1'b1, `PACD_IDX_IRQ_STAT, 32'h1);
    chk_bit(irq, 1'b0);
    end_of_test();
  end
endmodule : testbench
